// ===== pcs_clk_ctrl.sv
// Clock setup core: straps, PLL settings, boot wait, timers, clock block.
// Assumes an Avalon-MM master with word addresses and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pcs_clk_ctrl #(
    parameter int BOOT_WAIT = pcs_pkg::BOOT_WAIT_CLKS,
    parameter int LOCK_WAIT = pcs_pkg::LOCK_WAIT_CLKS,
    parameter int NUM_PORTS = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic clk_source_pick_n,
    input wire logic pll_sel_0,
    input wire logic pll_sel_1,
    input wire logic low_power_mode,
    input wire logic cb_ext_clk_pin,
    output logic cb_clk_o,
    output logic cb_clk_oe,
    output logic [NUM_PORTS-1:0] port_clk_en,
    output logic osc_use_silicon,
    output logic analog_clk_from_osc,
    output logic [11:0] pll_fb_mult,
    output logic [5:0] pll_ref_div,
    output logic [2:0] post_div_val,
    output logic pll_locked,
    output logic tile_clk_en,
    output logic switch_clk_en,
    output logic ref_clk_en,
    output logic pull_en,
    output logic cpu_run
);
    localparam int BW = $clog2(BOOT_WAIT + 1);
    localparam int LW = $clog2(LOCK_WAIT + 1);
    localparam int LPW = $clog2(pcs_pkg::LP_DIV_CYC + 1);
    localparam int RFW = $clog2(pcs_pkg::REF_DIV_CYC + 1);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [BW-1:0] boot_cnt;
        logic strap_done;
        logic booted;
        logic silicon;
        logic [1:0] sel;
        logic [11:0] pll_f;
        logic [5:0] pll_r;
        logic [2:0] pll_od;
        logic [LW-1:0] lock_cnt;
        logic locked;
        logic [RFW-1:0] ref_cnt;
        logic ref_tick;
        logic [31:0] timer;
        logic [LPW-1:0] lp_cnt;
        logic lp_tick;
        logic [31:0] rtc;
        logic cb_sel;
        logic cb_oe;
        logic [7:0] cb_div;
    } pcs_top_s;

    pcs_top_s st_ff;
    pcs_top_s nxt_st;
    pcs_cb_if cbi ();

    logic req;
    logic wr_go;
    logic clk_run;
    logic [12:0] ratio_num;
    logic [10:0] ratio_den;

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, then the answer
    // ------------------------------------------------------------
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~st_ff.ack;
    assign wr_go = avs_write & st_ff.ack;
    assign clk_run = st_ff.locked & ~low_power_mode;

    // ratio: tile = osc * num / den
    assign ratio_num = {1'b0, st_ff.pll_f} + 13'h0001;
    assign ratio_den = 11'({st_ff.pll_r, 1'b1} + 7'h01) *
        11'({1'b0, st_ff.pll_od} + 4'h1);

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req & ~st_ff.ack;
        nxt_st.s1 = {clk_source_pick_n, pll_sel_1, pll_sel_0};
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.ref_tick = 1'b0;
        nxt_st.lp_tick = 1'b0;

        // --------------------------------------------------------
        // Strap capture and boot wait
        // --------------------------------------------------------
        // Straps are caught once, so later strap motion cannot retune
        if (!st_ff.strap_done &&
            st_ff.boot_cnt >= BW'(pcs_pkg::STRAP_SETTLE_CYC) &&
            st_ff.s2 == st_ff.s3) begin
            nxt_st.strap_done = 1'b1;
            nxt_st.silicon = st_ff.s3[2];
            nxt_st.sel = st_ff.s3[1:0];
            nxt_st.pll_f = pcs_pkg::pcs_default_mult(st_ff.s3[1:0]);
            nxt_st.pll_r = pcs_pkg::REF_DIV_DEFAULT;
            nxt_st.pll_od = pcs_pkg::pcs_default_od(st_ff.s3[1:0]);
            nxt_st.lock_cnt = '0;
            nxt_st.locked = 1'b0;
        end
        if (st_ff.boot_cnt < BW'(BOOT_WAIT)) begin
            nxt_st.boot_cnt = st_ff.boot_cnt + BW'(1);
        end else if (st_ff.strap_done) begin
            nxt_st.booted = 1'b1;
        end

        // --------------------------------------------------------
        // PLL lock wait after any settings change
        // --------------------------------------------------------
        if (st_ff.strap_done && !st_ff.locked) begin
            if (st_ff.lock_cnt >= LW'(LOCK_WAIT)) begin
                nxt_st.locked = 1'b1;
            end else begin
                nxt_st.lock_cnt = st_ff.lock_cnt + LW'(1);
            end
        end

        // --------------------------------------------------------
        // Reference clock, timer and low-power counter
        // --------------------------------------------------------
        // Reference only runs while the PLL is locked and awake
        if (clk_run) begin
            if (st_ff.ref_cnt >= RFW'(pcs_pkg::REF_DIV_CYC - 1)) begin
                nxt_st.ref_cnt = '0;
                nxt_st.ref_tick = 1'b1;
            end else begin
                nxt_st.ref_cnt = st_ff.ref_cnt + RFW'(1);
            end
        end
        if (st_ff.ref_tick) begin
            nxt_st.timer = st_ff.timer + 32'h00000001;
        end
        // Runs regardless of low power or relock
        if (st_ff.lp_cnt >= LPW'(pcs_pkg::LP_DIV_CYC - 1)) begin
            nxt_st.lp_cnt = '0;
            nxt_st.lp_tick = 1'b1;
        end else begin
            nxt_st.lp_cnt = st_ff.lp_cnt + LPW'(1);
        end
        if (st_ff.lp_tick) begin
            nxt_st.rtc = st_ff.rtc + 32'h00000001;
        end

        // --------------------------------------------------------
        // Register reads, captured on the wait cycle
        // --------------------------------------------------------
        if (avs_read && !st_ff.ack) begin
            nxt_st.rdata = 32'h00000000;
            unique case (avs_address)
                pcs_pkg::REG_PLL_CFG: begin
                    nxt_st.rdata[pcs_pkg::F_LSB +: pcs_pkg::F_W] = st_ff.pll_f;
                    nxt_st.rdata[pcs_pkg::R_LSB +: pcs_pkg::R_W] = st_ff.pll_r;
                    nxt_st.rdata[pcs_pkg::OD_LSB +: pcs_pkg::OD_W] =
                        st_ff.pll_od;
                end
                pcs_pkg::REG_STATUS: begin
                    nxt_st.rdata[5:0] = {st_ff.booted, st_ff.locked,
                        st_ff.strap_done, st_ff.silicon, st_ff.sel};
                end
                pcs_pkg::REG_TIMER: nxt_st.rdata = st_ff.timer;
                pcs_pkg::REG_RTC: nxt_st.rdata = st_ff.rtc;
                pcs_pkg::REG_CB_CFG: begin
                    nxt_st.rdata[pcs_pkg::CB_SEL_BIT] = st_ff.cb_sel;
                    nxt_st.rdata[pcs_pkg::CB_OE_BIT] = st_ff.cb_oe;
                    nxt_st.rdata[pcs_pkg::CB_DIV_LSB +: pcs_pkg::CB_DIV_W] =
                        st_ff.cb_div;
                end
                pcs_pkg::REG_RATIO: begin
                    nxt_st.rdata[12:0] = ratio_num;
                    nxt_st.rdata[pcs_pkg::RATIO_DEN_LSB +: 11] = ratio_den;
                end
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end

        // --------------------------------------------------------
        // Register writes, taken when waitrequest is low
        // --------------------------------------------------------
        if (wr_go && avs_address == pcs_pkg::REG_PLL_CFG) begin
            // Field widths hold every value to its legal range
            nxt_st.pll_f = avs_writedata[pcs_pkg::F_LSB +: pcs_pkg::F_W];
            nxt_st.pll_r = avs_writedata[pcs_pkg::R_LSB +: pcs_pkg::R_W];
            nxt_st.pll_od =
                avs_writedata[pcs_pkg::OD_LSB +: pcs_pkg::OD_W];
            nxt_st.lock_cnt = '0;
            nxt_st.locked = 1'b0;
        end
        if (wr_go && avs_address == pcs_pkg::REG_CB_CFG) begin
            nxt_st.cb_sel = avs_writedata[pcs_pkg::CB_SEL_BIT];
            nxt_st.cb_oe = avs_writedata[pcs_pkg::CB_OE_BIT];
            nxt_st.cb_div =
                avs_writedata[pcs_pkg::CB_DIV_LSB +: pcs_pkg::CB_DIV_W];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.cb_div <= pcs_pkg::CB_DIV_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Clock block 0 and outputs
    // ------------------------------------------------------------
    assign cbi.ref_tick = st_ff.ref_tick;
    assign cbi.sel_ext = st_ff.cb_sel;
    assign cbi.out_en = st_ff.cb_oe;
    assign cbi.div = st_ff.cb_div;
    assign cbi.ext_pin = cb_ext_clk_pin;

    pcs_clk_block u_cb0 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cb(cbi.blk)
    );

    // Every port follows block 0; no per-port routing exists here
    assign port_clk_en = {NUM_PORTS{cbi.tick}};
    assign cb_clk_o = cbi.pin_o;
    assign cb_clk_oe = cbi.pin_oe;
    assign avs_readdata = st_ff.rdata;
    assign osc_use_silicon = st_ff.silicon;
    assign analog_clk_from_osc = 1'b1;
    assign pll_fb_mult = st_ff.pll_f;
    assign pll_ref_div = st_ff.pll_r;
    assign post_div_val = st_ff.pll_od;
    assign pll_locked = st_ff.locked;
    assign tile_clk_en = clk_run;
    assign switch_clk_en = clk_run;
    assign ref_clk_en = st_ff.ref_tick;
    assign pull_en = st_ff.booted;
    assign cpu_run = st_ff.booted & st_ff.locked;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_defaults;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(st_ff.strap_done) |-> pll_fb_mult ==
            pcs_pkg::pcs_default_mult(st_ff.sel) && pll_ref_div == 6'h00;
    endproperty
    a_defaults: assert property (p_defaults) else $error("bad mult");

    property p_od;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(st_ff.strap_done) |->
            post_div_val == ((st_ff.sel == 2'b00) ? 3'h1 : 3'h2);
    endproperty
    a_od: assert property (p_od) else $error("bad post divider");

    property p_osc;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(st_ff.strap_done) |-> osc_use_silicon == $past(st_ff.s3[2]);
    endproperty
    a_osc: assert property (p_osc) else $error("bad source");

    property p_pll_wr;
        @(posedge core_clk) disable iff (!rst_n)
        (avs_write && !avs_waitrequest &&
            avs_address == pcs_pkg::REG_PLL_CFG) |=>
            pll_fb_mult == $past(avs_writedata[11:0]) && !tile_clk_en;
    endproperty
    a_pll_wr: assert property (p_pll_wr) else $error("write lost");

    property p_gate;
        @(posedge core_clk) disable iff (!rst_n)
        !pll_locked |-> !tile_clk_en && !switch_clk_en ##1 !ref_clk_en;
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");

    property p_timer;
        @(posedge core_clk) disable iff (!rst_n)
        ref_clk_en |=> st_ff.timer == $past(st_ff.timer) + 32'h00000001;
    endproperty
    a_timer: assert property (p_timer) else $error("timer stuck");

    property p_rtc;
        @(posedge core_clk) disable iff (!rst_n)
        st_ff.lp_tick |=> st_ff.rtc == $past(st_ff.rtc) + 32'h00000001;
    endproperty
    a_rtc: assert property (p_rtc) else $error("rtc stuck");

    property p_boot;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(pull_en) |-> st_ff.boot_cnt == BW'(BOOT_WAIT);
    endproperty
    a_boot: assert property (p_boot) else $error("early boot");

    property p_wait;
        @(posedge core_clk) disable iff (!rst_n)
        avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait too long");
endmodule
`default_nettype wire

// ===== pcs_pkg.sv
// Constants used by the clock setup block, including its clock block register fields.
// Assumes one 100 MHz core clock and a word-indexed Avalon-MM slave.
package pcs_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CORE_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int REF_HZ = 100_000_000;
    localparam int REF_DIV_CYC = CORE_HZ / REF_HZ;
    localparam int TIMER_TICK_NS = 10;
    localparam int LP_HZ = 31_250;
    localparam int LP_DIV_CYC = CORE_HZ / LP_HZ;
    localparam int BOOT_WAIT_CLKS = 750_000;
    localparam int LOCK_WAIT_CLKS = 500;
    localparam int SILICON_OSC_MHZ = 20;
    localparam int STRAP_SETTLE_CYC = 4;

    // ------------------------------------------------------------
    // Register word indices (byte address = 4 x index)
    // ------------------------------------------------------------
    localparam logic [2:0] REG_PLL_CFG = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_TIMER = 3'h2;
    localparam logic [2:0] REG_RTC = 3'h3;
    localparam logic [2:0] REG_CB_CFG = 3'h4;
    localparam logic [2:0] REG_RATIO = 3'h5;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int F_LSB = 0;
    localparam int F_W = 12;
    localparam int R_LSB = 16;
    localparam int R_W = 6;
    localparam int OD_LSB = 24;
    localparam int OD_W = 3;
    localparam int CB_SEL_BIT = 0;
    localparam int CB_OE_BIT = 1;
    localparam int CB_DIV_LSB = 8;
    localparam int CB_DIV_W = 8;
    localparam int RATIO_DEN_LSB = 16;

    // ------------------------------------------------------------
    // Strap defaults
    // ------------------------------------------------------------
    localparam logic [11:0] MULT_SEL_00 = 12'h07a;
    localparam logic [11:0] MULT_SEL_11 = 12'h077;
    localparam logic [11:0] MULT_SEL_10 = 12'h031;
    localparam logic [11:0] MULT_SEL_01 = 12'h017;
    localparam logic [5:0] REF_DIV_DEFAULT = 6'h00;
    localparam logic [2:0] OD_SEL_00 = 3'h1;
    localparam logic [2:0] OD_OTHER = 3'h2;
    localparam logic [7:0] CB_DIV_RESET = 8'h00;

    function automatic logic [11:0] pcs_default_mult(input logic [1:0] sel);
        logic [11:0] m;
        m = MULT_SEL_00;
        unique case (sel)
            2'b00: m = MULT_SEL_00;
            2'b11: m = MULT_SEL_11;
            2'b10: m = MULT_SEL_10;
            2'b01: m = MULT_SEL_01;
        endcase
        return m;
    endfunction

    function automatic logic [2:0] pcs_default_od(input logic [1:0] sel);
        return (sel == 2'b00) ? OD_SEL_00 : OD_OTHER;
    endfunction
endpackage

// ===== pcs_cb_if.sv
// Signals between the clock setup core and one clock block.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface pcs_cb_if;
    logic ref_tick;
    logic sel_ext;
    logic out_en;
    logic [7:0] div;
    logic ext_pin;
    logic tick;
    logic pin_o;
    logic pin_oe;
    modport core (output ref_tick, output sel_ext, output out_en,
        output div, output ext_pin, input tick, input pin_o, input pin_oe);
    modport blk (input ref_tick, input sel_ext, input out_en,
        input div, input ext_pin, output tick, output pin_o, output pin_oe);
endinterface
`default_nettype wire

// ===== pcs_clk_block.sv
// One port clock block: external pin or divided reference clock.
// Assumes the external pin is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pcs_clk_block (
    input wire logic core_clk,
    input wire logic rst_n,
    pcs_cb_if.blk cb
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
        logic [7:0] cnt;
        logic tick;
        logic pin;
    } pcs_cb_s;

    pcs_cb_s st_ff;
    pcs_cb_s nxt_st;

    // ------------------------------------------------------------
    // Source select and divide
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = cb.ext_pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.tick = 1'b0;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.stable = st_ff.s3;
        end
        if (cb.sel_ext) begin
            nxt_st.cnt = 8'h00;
            nxt_st.pin = nxt_st.stable;
            nxt_st.tick = nxt_st.stable & ~st_ff.stable;
        end else if (cb.ref_tick) begin
            if (st_ff.cnt >= cb.div) begin
                nxt_st.cnt = 8'h00;
                nxt_st.tick = 1'b1;
                nxt_st.pin = ~st_ff.pin;
            end else begin
                nxt_st.cnt = st_ff.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cb.tick = st_ff.tick;
    assign cb.pin_o = st_ff.pin;
    assign cb.pin_oe = cb.out_en;

    property p_ref_div;
        @(posedge core_clk) disable iff (!rst_n)
        (!cb.sel_ext && cb.ref_tick && st_ff.cnt >= cb.div) |=> st_ff.tick;
    endproperty
    a_ref_div: assert property (p_ref_div) else $error("ref tick lost");
endmodule
`default_nettype wire

// ===== pcs_board_model.sv
// Board model: strap pins and an external clock source for clock block 0.
// Assumes the bench sets strap levels only while reset is held.
`timescale 1ns/1ps
`default_nettype none
module pcs_board_model (
    input wire logic src_n,
    input wire logic [1:0] sel,
    input wire logic ext_run,
    output logic clk_source_pick_n,
    output logic pll_sel_0,
    output logic pll_sel_1,
    output var logic ext_pin
);
    // Straps are tied levels, never moved outside reset
    assign clk_source_pick_n = src_n;
    assign pll_sel_0 = sel[0];
    assign pll_sel_1 = sel[1];
    // Free source, unrelated in phase to core_clk; held low when stopped
    initial begin
        ext_pin = 1'b0;
        forever begin
            #37;
            ext_pin = ext_run ? ~ext_pin : 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== pll_clock_setup_test.sv
// Bench for the clock setup core: boot, PLL rewrite, clock block, timers.
// Assumes the board model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_setup_test;
    localparam int BW = 200;
    localparam int LW = 8;
    logic core_clk, rst_n, avs_read, avs_write, src_n, ext_run;
    logic [2:0] avs_address, post_div_val;
    logic [31:0] avs_writedata, avs_readdata, q, a;
    logic avs_waitrequest, pick_n, s0, s1, ext_pin, low_power_mode;
    logic cb_clk_o, cb_clk_oe, osc_use_silicon, analog_clk_from_osc;
    logic pll_locked, tile_clk_en, switch_clk_en, ref_clk_en;
    logic pull_en, cpu_run;
    logic [1:0] sel;
    logic [7:0] port_clk_en;
    logic [11:0] pll_fb_mult;
    logic [5:0] pll_ref_div;
    int seed = 20251;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int t0, c, f, r, pd;

    pcs_clk_ctrl #(.BOOT_WAIT(BW), .LOCK_WAIT(LW), .NUM_PORTS(8)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .clk_source_pick_n(pick_n),
        .pll_sel_0(s0), .pll_sel_1(s1), .low_power_mode(low_power_mode),
        .cb_ext_clk_pin(ext_pin), .cb_clk_o(cb_clk_o),
        .cb_clk_oe(cb_clk_oe), .port_clk_en(port_clk_en),
        .osc_use_silicon(osc_use_silicon),
        .analog_clk_from_osc(analog_clk_from_osc),
        .pll_fb_mult(pll_fb_mult), .pll_ref_div(pll_ref_div),
        .post_div_val(post_div_val), .pll_locked(pll_locked),
        .tile_clk_en(tile_clk_en), .switch_clk_en(switch_clk_en),
        .ref_clk_en(ref_clk_en), .pull_en(pull_en), .cpu_run(cpu_run));

    pcs_board_model board (.src_n(src_n), .sel(sel), .ext_run(ext_run),
        .clk_source_pick_n(pick_n), .pll_sel_0(s0), .pll_sel_1(s1),
        .ext_pin(ext_pin));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] exp_mult(input logic [1:0] m);
        case (m)
            2'b00: return 12'h07a;
            2'b11: return 12'h077;
            2'b10: return 12'h031;
            default: return 12'h017;
        endcase
    endfunction

    function automatic logic [31:0] ratio(input int f, r, d);
        return 32'((2 * (r + 1) * (d + 1)) << 16) | 32'(f + 1);
    endfunction

    task automatic stop_test();
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge;
    // only the hang guard ends a wait that never gets an answer
    task automatic bus(input logic wr, input logic [2:0] ad,
        input logic [31:0] d, output logic [31:0] rd);
        @(posedge core_clk);
        avs_address <= ad;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic count(input int n, input bit w, output int k);
        k = 0;
        repeat (n) begin
            @(negedge core_clk);
            if ((w ? ref_clk_en : port_clk_en[0]) === 1'b1) k++;
        end
    endtask

    task automatic wait_hi(input int lim, input bit w, output int k);
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while ((w ? pull_en : pll_locked) !== 1'b1 && k < lim);
    endtask

    task automatic boot(input logic s, input logic [1:0] m);
        @(posedge core_clk);
        rst_n <= 1'b0;
        src_n <= s;
        sel <= m;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        t0 = cyc;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Hang guard, well above the roughly 7200 cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        avs_address = 3'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        src_n = 1'b1;
        sel = 2'h0;
        ext_run = 1'b0;
        low_power_mode = 1'b0;
        for (int i = 0; i < 4; i++) begin
            boot(1'($random(seed)), 2'(i));
            wait_hi(40, 0, c);
            chk(osc_use_silicon, src_n);
            chk(analog_clk_from_osc, 1);
            chk(pll_fb_mult, exp_mult(2'(i)));
            chk(pll_ref_div, 0);
            chk(post_div_val, i == 0 ? 1 : 2);
            chk(tile_clk_en & switch_clk_en, 1);
        end
        chk(pull_en | cpu_run, 0);
        wait_hi(300, 1, c);
        chk(32'(cyc - t0 >= BW - 2 && cyc - t0 <= BW + 3), 1);
        chk(cpu_run, 1);
        bus(0, 3'h1, 0, q);
        chk(q, {26'h0, 3'h7, src_n, sel});
        bus(0, 3'h5, 0, q);
        chk(q, ratio(exp_mult(sel), 0, 2));
        count(20, 1, c);
        chk(c, 20);
        count(20, 0, c);
        chk(c, 20);
        bus(0, 3'h2, 0, q);
        bus(0, 3'h2, 0, a);
        chk(a - q, 3);
        bus(1, 3'h6, $random(seed), q);
        bus(0, 3'h6, 0, q);
        chk(q, 0);
        bus(0, 3'h7, 0, q);
        chk(q, 0);
        // Random rewrites kept legal, first one at the field limits
        for (int k = 0; k < 5; k++) begin
            r = {$random(seed)} % 8;
            f = (r + 1) * (26 + {$random(seed)} % 105) - 1;
            pd = {$random(seed)} % 8;
            if (k == 0) begin
                r = 63;
                f = 4095;
                pd = 7;
            end
            bus(1, 3'h0, (pd << 24) | (r << 16) | f, q);
            @(negedge core_clk);
            chk(pll_locked | tile_clk_en, 0);
            chk({pll_fb_mult, pll_ref_div, post_div_val},
                {f[11:0], r[5:0], pd[2:0]});
            wait_hi(40, 0, c);
            chk(32'(c >= LW - 1 && c <= LW + 2), 1);
            bus(0, 3'h5, 0, q);
            chk(q, ratio(f, r, pd));
            bus(0, 3'h0, 0, q);
            chk(q, (pd << 24) | (r << 16) | f);
        end
        bus(1, 3'h4, 32'h0302, q);
        @(negedge core_clk);
        chk(cb_clk_oe, 1);
        count(40, 0, c);
        chk(32'(c >= 9 && c <= 10), 1);
        ext_run <= 1'b1;
        bus(1, 3'h4, 32'h0001, q);
        count(200, 0, c);
        chk(32'(c >= 20 && c <= 60), 1);
        ext_run <= 1'b0;
        count(10, 0, c);
        count(50, 0, c);
        chk({cb_clk_oe, cb_clk_o, 8'(c)}, 0);
        @(posedge core_clk);
        low_power_mode <= 1'b1;
        bus(0, 3'h3, 0, q);
        @(negedge core_clk);
        // Low power stops the fast clocks but not the booted processor
        chk({tile_clk_en, switch_clk_en, cpu_run}, 32'h1);
        count(20, 1, c);
        chk(c, 0);
        repeat (6400) @(posedge core_clk);
        bus(0, 3'h3, 0, a);
        chk(32'(a - q >= 2 && a - q <= 3), 1);
        low_power_mode <= 1'b0;
        @(negedge core_clk);
        chk(tile_clk_en, 1);
        stop_test();
    end
endmodule
`default_nettype wire
